// *** bbl_core.sv ***
// instruction decode and execute core with its file registers and timers
// assumes program memory answers combinationally on the same clock
//
// The Wishbone register port and the address map were left to the implementer.
`timescale 1ns/1ns
`default_nettype none

// What this block does
// - self-modifying port operations read the synchronised pin levels, not the latch
// - file write to timer count clears prescaler when prescaler belongs to timer
// - branches and taken skips take two cycles, second one a no-op
// - add-literal adds immediate to accumulator, updates carry, nibble carry, zero
// - add-accumulator-to-file adds, routes by destination bit, updates three flags
// - bit clear and bit set force one file bit, flags untouched
// - skip-if-bit-set discards next instruction when tested bit is one
// - skip-if-bit-clear discards next instruction when tested bit is zero
// - and-literal ands immediate into accumulator, zero flag only
// - and-accumulator-with-file ands, routes by destination bit, zero flag only
// - call pushes pointer plus one, loads target and latch bits 4..3
// - jump loads eleven bits plus latch bits 4..3, two cycles, no flags
// - watchdog kick clears counter and prescaler, sets expiry and sleep bits
// - file zeroize writes zero to file register and sets zero flag
// - accumulator zeroize writes zero to accumulator and sets zero flag
// - file invert complements file, routes by destination bit, zero flag
// - file decrement and increment adjust by one, route result, zero flag
// - decrement-skip stores result, skips next when zero, no flags
// - increment-skip stores result, skips next when zero, no flags
// - or-literal ors immediate into accumulator, zero flag only
// - or-accumulator-with-file ors, routes by destination bit, zero flag
// - one instruction cycle spans four clocks
// - word fields: opcode 13..8, destination 7, address 6..0, bit 9..7
module bbl_core
    import bbl_pkg::*;
(
    input wire logic clk,
    input wire logic reset,
    input wire logic clkEn,
    output logic [PC_W-1:0] progAddr,
    input wire logic [WORD_W-1:0] progData,
    input wire logic [7:0] portPins,
    output logic [7:0] portOut,
    output logic watchdogExpired,
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [7:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    output logic [31:0] dat_o,
    output logic ack_o
);

    bbl_phase_t phase, next_phase;
    logic [7:0] pinMeta, pinSync;
    logic [PC_W-1:0] pc, next_pc;
    logic [WORD_W-1:0] instr, next_instr;
    logic instrValid, next_instrValid, flush, next_flush;
    logic [7:0] acc, next_acc, status, next_status, timerCount, next_timerCount;
    logic [7:0] presc, next_presc, watchdog, next_watchdog, portLatch, next_portLatch;
    logic [4:0] pcLatch, next_pcLatch;
    logic [2:0] sp, next_sp;
    logic expiryPulse, next_expiryPulse;
    logic [7:0] fileRam [FILE_DEPTH];
    logic [PC_W-1:0] stack [STACK_DEPTH];
    logic ramWe, pushEn;
    logic [6:0] ramAddr;
    logic [7:0] ramData;
    logic [7:0] ctrl, next_ctrl;
    logic ack, next_ack;
    logic [31:0] rdData, next_rdData;

    // operand fetch for execute, special file addresses replace the RAM word
    function automatic logic [7:0] read_file(input logic [6:0] a, input logic [7:0] ram,
            input logic [7:0] pins, input logic [7:0] st, input logic [7:0] tmr,
            input logic [4:0] lat);
        logic [7:0] v;
        v = ram;
        if (a == FA_PORT) begin
            v = pins;
        end else if (a == FA_STATUS) begin
            v = st;
        end else if (a == FA_TIMER) begin
            v = tmr;
        end else if (a == FA_PCLATCH) begin
            v = {3'h0, lat};
        end
        return v;
    endfunction

    function automatic bbl_op_t decode(input logic [WORD_W-1:0] w);
        bbl_op_t op;
        op = OP_NONE;
        case (w[13:12])
            2'b00: begin
                if (w == WORD_WATCHDOG_KICK) begin
                    op = OP_WATCHDOG_KICK;
                end else begin
                    case (w[OPC_HI:OPC_LO])
                        OPC_ADD_FILE: op = OP_ADD_ACC_FILE;
                        OPC_AND_FILE: op = OP_AND_ACC_FILE;
                        OPC_OR_FILE: op = OP_OR_ACC_FILE;
                        OPC_CLEAR: op = w[DEST_BIT] ? OP_FILE_ZERO : OP_ACC_ZERO;
                        OPC_INVERT: op = OP_FILE_INV;
                        OPC_DEC: op = OP_FILE_DEC;
                        OPC_DEC_SKIP: op = OP_FILE_DEC_SKIP;
                        OPC_INC: op = OP_FILE_INC;
                        OPC_INC_SKIP: op = OP_FILE_INC_SKIP;
                        default: op = OP_NONE;
                    endcase
                end
            end
            2'b01: begin
                case (w[11:10])
                    2'b00: op = OP_BIT_CLEAR;
                    2'b01: op = OP_BIT_SET;
                    2'b10: op = OP_SKIP_CLEAR;
                    default: op = OP_SKIP_SET;
                endcase
            end
            2'b10: op = w[11] ? OP_JUMP : OP_CALL;
            default: begin
                if (w[11:9] == OPC_ADD_LIT) begin
                    op = OP_ADD_LIT_ACC;
                end else if (w[11:8] == OPC_AND_LIT) begin
                    op = OP_AND_LIT_ACC;
                end else if (w[11:8] == OPC_OR_LIT) begin
                    op = OP_OR_LIT_ACC;
                end
            end
        endcase
        return op;
    endfunction

    // pins come from outside, two flops before use
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            pinMeta <= 8'h00;
            pinSync <= 8'h00;
        end else if (clkEn) begin
            pinMeta <= portPins;
            pinSync <= pinMeta;
        end
    end

    always_comb begin
        next_phase = phase;
        case (phase)
            PH0: next_phase = PH1;
            PH1: next_phase = PH2;
            PH2: next_phase = PH3;
            PH3: next_phase = PH0;
            default: next_phase = PH0;
        endcase
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            phase <= PH0;
        end else if (clkEn) begin
            phase <= next_phase;
        end
    end

    bbl_op_t op;
    logic tick, presDone, destFile, wrFile, skip, flagsZ, flagsAdd, doExec;
    logic [6:0] fAddr;
    logic [2:0] bitNo;
    logic [7:0] fileVal, lit, res, rateMask, bitMask;
    logic [8:0] sum;
    logic [4:0] nibSum;

    always_comb begin
        fAddr = instr[FADDR_HI:0];
        bitNo = instr[BITNO_HI:BITNO_LO];
        destFile = instr[DEST_BIT];
        lit = instr[7:0];
        op = decode(instr);
        fileVal = read_file(fAddr, fileRam[fAddr], pinSync, status, timerCount, pcLatch);
        bitMask = 8'h01 << bitNo;
        rateMask = 8'((9'h002 << ctrl[CTRL_RATE_HI:CTRL_RATE_LO]) - 9'h001);
        presDone = &(presc | ~rateMask);
        tick = (phase == PH3) && ctrl[CTRL_RUN];
        doExec = tick && instrValid && !flush;
        // carry from bit 7, nibble carry from bit 3
        sum = {1'b0, acc} + {1'b0, (op == OP_ADD_LIT_ACC) ? lit : fileVal};
        nibSum = {1'b0, acc[3:0]} + {1'b0, (op == OP_ADD_LIT_ACC) ? lit[3:0] : fileVal[3:0]};
        res = fileVal;
        wrFile = 1'b0;
        skip = 1'b0;
        flagsZ = 1'b0;
        flagsAdd = 1'b0;
        case (op)
            OP_ADD_LIT_ACC: begin
                res = sum[7:0];
                flagsAdd = 1'b1;
            end
            OP_ADD_ACC_FILE: begin
                res = sum[7:0];
                wrFile = destFile;
                flagsAdd = 1'b1;
            end
            OP_AND_LIT_ACC: begin
                res = acc & lit;
                flagsZ = 1'b1;
            end
            OP_AND_ACC_FILE: begin
                res = acc & fileVal;
                wrFile = destFile;
                flagsZ = 1'b1;
            end
            OP_OR_LIT_ACC: begin
                res = acc | lit;
                flagsZ = 1'b1;
            end
            OP_OR_ACC_FILE: begin
                res = acc | fileVal;
                wrFile = destFile;
                flagsZ = 1'b1;
            end
            OP_FILE_ZERO: begin
                res = 8'h00;
                wrFile = 1'b1;
                flagsZ = 1'b1;
            end
            OP_ACC_ZERO: begin
                res = 8'h00;
                flagsZ = 1'b1;
            end
            OP_FILE_INV: begin
                res = ~fileVal;
                wrFile = destFile;
                flagsZ = 1'b1;
            end
            OP_FILE_DEC, OP_FILE_INC: begin
                res = (op == OP_FILE_INC) ? fileVal + 8'h01 : fileVal - 8'h01;
                wrFile = destFile;
                flagsZ = 1'b1;
            end
            OP_FILE_DEC_SKIP, OP_FILE_INC_SKIP: begin
                res = (op == OP_FILE_INC_SKIP) ? fileVal + 8'h01 : fileVal - 8'h01;
                wrFile = destFile;
                skip = (res == 8'h00);
            end
            OP_BIT_CLEAR, OP_BIT_SET: begin
                res = (op == OP_BIT_SET) ? (fileVal | bitMask) : (fileVal & ~bitMask);
                wrFile = 1'b1;
            end
            OP_SKIP_CLEAR: skip = ((fileVal & bitMask) == 8'h00);
            OP_SKIP_SET: skip = ((fileVal & bitMask) != 8'h00);
            default: res = fileVal;
        endcase
    end

    always_comb begin
        next_pc = pc;
        next_instr = instr;
        next_instrValid = instrValid;
        next_flush = flush;
        next_acc = acc;
        next_status = status;
        next_timerCount = timerCount;
        next_presc = presc;
        next_watchdog = watchdog;
        next_portLatch = portLatch;
        next_pcLatch = pcLatch;
        next_sp = sp;
        next_expiryPulse = 1'b0;
        ramWe = 1'b0;
        ramAddr = fAddr;
        ramData = res;
        pushEn = 1'b0;
        if (tick) begin
            next_instr = progData;
            next_instrValid = 1'b1;
            next_flush = 1'b0;
            next_pc = pc + 13'h0001;
            next_presc = presc + 8'h01;
            // shared prescaler feeds either timer or watchdog
            if (ctrl[CTRL_PRESC_TIMER]) begin
                next_timerCount = presDone ? timerCount + 8'h01 : timerCount;
                next_watchdog = watchdog + 8'h01;
            end else begin
                next_timerCount = timerCount + 8'h01;
                next_watchdog = presDone ? watchdog + 8'h01 : watchdog;
            end
            if (next_watchdog == 8'h00 && watchdog == 8'hff) begin
                next_status[ST_EXPIRY] = 1'b0;
                next_expiryPulse = 1'b1;
            end
        end
        if (doExec) begin
            if (wrFile) begin
                if (fAddr == FA_STATUS) begin
                    next_status[ST_ZERO:ST_CARRY] = res[ST_ZERO:ST_CARRY];
                end else if (fAddr == FA_TIMER) begin
                    next_timerCount = res;
                    if (ctrl[CTRL_PRESC_TIMER]) begin
                        next_presc = 8'h00;
                    end
                end else if (fAddr == FA_PORT) begin
                    next_portLatch = res;
                end else if (fAddr == FA_PCLATCH) begin
                    next_pcLatch = res[4:0];
                end else begin
                    ramWe = 1'b1;
                end
            end else if (op != OP_NONE && op != OP_BIT_CLEAR && op != OP_BIT_SET
                    && op != OP_SKIP_CLEAR && op != OP_SKIP_SET && op != OP_CALL
                    && op != OP_JUMP && op != OP_WATCHDOG_KICK) begin
                next_acc = res;
            end
            if (flagsZ || flagsAdd) begin
                next_status[ST_ZERO] = (res == 8'h00);
            end
            if (flagsAdd) begin
                next_status[ST_CARRY] = sum[8];
                next_status[ST_NIBBLE] = nibSum[4];
            end
            // taken skip costs a no-op cycle
            if (skip) begin
                next_flush = 1'b1;
            end
            if (op == OP_CALL || op == OP_JUMP) begin
                next_pc = {pcLatch[PCLATCH_HI:PCLATCH_LO], instr[JUMP_HI:0]};
                next_flush = 1'b1;
            end
            // return address is the already advanced pointer
            if (op == OP_CALL) begin
                pushEn = 1'b1;
                next_sp = sp + 3'h1;
            end
            if (op == OP_WATCHDOG_KICK) begin
                next_watchdog = 8'h00;
                next_presc = 8'h00;
                next_status[ST_EXPIRY] = 1'b1;
                next_status[ST_SLEEP] = 1'b1;
                next_expiryPulse = 1'b0;
            end
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            pc <= '0;
            instr <= '0;
            instrValid <= 1'b0;
            flush <= 1'b0;
            acc <= 8'h00;
            status <= STATUS_RESET;
            timerCount <= 8'h00;
            presc <= 8'h00;
            watchdog <= 8'h00;
            portLatch <= 8'h00;
            pcLatch <= 5'h00;
            sp <= 3'h0;
            expiryPulse <= 1'b0;
        end else if (clkEn) begin
            pc <= next_pc;
            instr <= next_instr;
            instrValid <= next_instrValid;
            flush <= next_flush;
            acc <= next_acc;
            status <= next_status;
            timerCount <= next_timerCount;
            presc <= next_presc;
            watchdog <= next_watchdog;
            portLatch <= next_portLatch;
            pcLatch <= next_pcLatch;
            sp <= next_sp;
            expiryPulse <= next_expiryPulse;
        end
    end

    // arrays carry no reset, contents are undefined until written
    always_ff @(posedge clk) begin
        if (clkEn && ramWe) begin
            fileRam[ramAddr] <= ramData;
        end
        if (clkEn && pushEn) begin
            stack[sp] <= pc;
        end
    end

    // wishbone slave, ack one cycle after the strobe, writes commit with ack
    always_comb begin
        next_ctrl = ctrl;
        next_ack = cyc_i && stb_i && !ack;
        next_rdData = rdData;
        if (cyc_i && stb_i && !ack) begin
            if (adr_i == ADR_CTRL) begin
                next_rdData = {24'h000000, ctrl};
            end else if (adr_i == ADR_CORE) begin
                next_rdData = {3'h0, pc, status, acc};
            end else if (adr_i == ADR_TIMERS) begin
                next_rdData = {8'h00, presc, watchdog, timerCount};
            end else if (adr_i == ADR_STACK) begin
                next_rdData = {13'h0000, sp, 3'h0, stack[sp - 3'h1]};
            end else begin
                next_rdData = 32'h00000000;
            end
        end
        if (cyc_i && stb_i && ack && we_i && sel_i[0] && adr_i == ADR_CTRL) begin
            next_ctrl = dat_i[7:0];
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            ctrl <= CTRL_RESET;
            ack <= 1'b0;
            rdData <= 32'h00000000;
        end else if (clkEn) begin
            ctrl <= next_ctrl;
            ack <= next_ack;
            rdData <= next_rdData;
        end
    end

    assign progAddr = pc;
    assign portOut = portLatch;
    assign watchdogExpired = expiryPulse;
    assign dat_o = rdData;
    assign ack_o = ack;

endmodule // bbl_core

`default_nettype wire

// *** bbl_core_bench.sv ***
// bench: one directed program, then random programs, run on the core and on a reference model
// assumes the program memory model and the bound checker
`timescale 1ns/1ns
`default_nettype none
module bbl_core_bench
    import bbl_pkg::*;
();
    logic clk, reset, cyc, stb, we, ack;
    logic [3:0] sel;
    logic [7:0] adr, pins, portOut, acc;
    logic [31:0] datI, datO, q;
    logic [PC_W-1:0] progAddr, pc, head;
    logic [WORD_W-1:0] progData;
    logic [WORD_W-1:0] prog [64];
    logic [7:0] f [128];
    logic [2:0] st;
    logic [3:0] lits [4] = '{4'hf, 4'he, 4'h9, 4'h8};
    logic [3:0] ops [9] = '{4'h7, 4'h5, 4'h1, 4'h9, 4'h3, 4'hb, 4'ha, 4'hf, 4'h4};
    int seed = 24785;
    int miscompares = 0;
    int nCompared = 0;
    bbl_core i_dut (.clk(clk), .reset(reset), .clkEn(1'b1), .progAddr(progAddr),
        .progData(progData), .portPins(pins), .portOut(portOut), .watchdogExpired(),
        .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr), .sel_i(sel), .dat_i(datI),
        .dat_o(datO), .ack_o(ack));
    bbl_prog_mem i_mem (.progAddr(progAddr), .progData(progData));
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    task automatic finish_test();
        if (miscompares == 0 && nCompared > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        nCompared++;
        if (seen !== exp) begin
            miscompares++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        datI <= d;
        sel <= 4'hf;
        do @(posedge clk); while (ack !== 1'b1);
        q = datO;
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask
    // reference model of one instruction
    task automatic step();
        logic [13:0] w;
        logic [8:0] s;
        logic [7:0] r, b, v;
        logic [3:0] o;
        logic d, sk;
        w = prog[pc[5:0]];
        pc = pc + 13'h1;
        r = (w[6:0] == FA_PORT) ? pins : f[w[6:0]];
        d = w[7];
        o = w[11:8];
        b = r;
        v = 8'h00;
        sk = 1'b0;
        if (w[13:12] == 2'b10) begin
            if (!w[11]) head = pc;
            pc = {f[FA_PCLATCH][4:3], w[10:0]};
            o = 4'h0;
        end else if (w[13:12] == 2'b01) begin
            sk = w[11] && r[w[9:7]] == w[10];
            r[w[9:7]] = w[10];
            if (!w[11]) f[w[6:0]] = r;
            o = 4'h0;
        end else if (w[13:12] == 2'b11) begin
            b = w[7:0];
            d = 1'b0;
            o = w[11:9] == 3'b111 ? 4'h7 : w[11:8] == 4'h9 ? 4'h5 : w[11:8] == 4'h8 ? 4'h4 : 4'h0;
        end
        case (o)
            4'h7: begin
                s = acc + b;
                st[0] = s[8];
                st[1] = (acc[3:0] + b[3:0]) > 5'h0f;
                v = s[7:0];
            end
            4'h5: v = acc & b;
            4'h4: v = acc | b;
            4'h1: v = 8'h00;
            4'h9: v = ~b;
            4'h3, 4'hb: v = b - 8'h01;
            4'ha, 4'hf: v = b + 8'h01;
            default: o = 4'h0;
        endcase
        if (o != 4'h0) begin
            if (o == 4'hb || o == 4'hf) sk = v == 8'h00;
            else st[2] = v == 8'h00;
            if (d) f[w[6:0]] = v;
            else acc = v;
        end
        if (sk) pc = pc + 13'h1;
    endtask
    task automatic build(input logic dir);
        int r;
        logic [6:0] a;
        prog = '{default: 14'h0000};
        prog[0] = 14'h0100;
        prog[1] = {OPC_CLEAR, 1'b1, FA_PCLATCH};
        if (dir) begin
            // latch bits 4..3 set, then branch behind branch
            prog[2] = 14'h3818;
            prog[3] = {OPC_OR_FILE, 1'b1, FA_PCLATCH};
            prog[4] = 14'h2810;
            prog[5] = 14'h2830;
            prog[16] = 14'h2020;
            prog[17] = 14'h2830;
            prog[32] = 14'h2820;
        end else begin
            prog[2] = {OPC_CLEAR, 1'b1, 7'h20};
            prog[3] = {OPC_CLEAR, 1'b1, 7'h21};
            for (int i = 4; i < 13; i++) begin
                r = $random(seed);
                // no port write behind a skip: the checker cannot see skips
                a = (r[9] && prog[i-1][13:11] != 3'b011 && !(prog[i-1][13:8] ==? 6'b001?11))
                    ? FA_PORT : {6'h10, r[8]};
                case (r[1:0])
                    2'h0: prog[i] = {2'b11, lits[r[3:2]], r[15:8]};
                    2'h1: prog[i] = {2'b01, r[3:2], r[6:4], a};
                    default: prog[i] = {2'b00, ops[r[6:2] % 9], r[7], a};
                endcase
            end
            prog[14] = 14'h280e;
        end
    endtask
    task automatic trial(input logic dir);
        int n;
        build(dir);
        reset <= 1'b1;
        pins <= 8'($random(seed));
        @(posedge clk);
        for (int i = 0; i < 64; i++) i_mem.mem[i] = prog[i];
        repeat (9) @(posedge clk);
        reset <= 1'b0;
        f = '{default: 8'h00};
        acc = 8'h00;
        st = 3'h0;
        pc = '0;
        head = '0;
        n = 0;
        bus(1'b1, ADR_CTRL, 32'h1);
        while (prog[pc[5:0]] !== {3'b101, pc[10:0]} && n < 100) begin
            step();
            n++;
        end
        repeat (300) @(posedge clk);
        bus(1'b0, ADR_CORE, 32'h0);
        check(q & 32'h1ffe_07ff, {3'h0, pc, 5'h00, st, acc} & 32'h1ffe_07ff);
        check({24'h0, portOut}, {24'h0, f[FA_PORT]});
        if (dir) begin
            bus(1'b0, ADR_STACK, 32'h0);
            check({19'h0, q[12:0]}, {19'h0, head});
        end
    endtask
    initial begin
        #1_000_000;
        miscompares++;
        finish_test();
    end
    initial begin
        reset = 1'b1;
        cyc = 1'b0;
        stb = 1'b0;
        we = 1'b0;
        adr = 8'h00;
        sel = 4'h0;
        datI = 32'h0;
        pins = 8'h00;
        repeat (10) @(posedge clk);
        reset <= 1'b0;
        bus(1'b0, ADR_CTRL, 32'h0);
        check(q, {24'h0, CTRL_RESET});
        bus(1'b1, ADR_CTRL, 32'h1c);
        bus(1'b0, ADR_CTRL, 32'h0);
        check(q, 32'h1c);
        bus(1'b0, 8'h10, 32'h0);
        check(q, 32'h0);
        for (int t = 0; t < 60; t++) trial(t == 0);
        finish_test();
    end
endmodule // bbl_core_bench
`default_nettype wire

// *** bbl_core_monitor.sv ***
// checker for the instruction core: fetch address stepping and port writes
// assumes words come from a memory that answers in the same cycle
`timescale 1ns/1ns
`default_nettype none
module bbl_core_monitor
    import bbl_pkg::*;
(
    input wire logic clk,
    input wire logic reset,
    input wire logic [PC_W-1:0] progAddr,
    input wire logic [WORD_W-1:0] progData,
    input wire logic [7:0] portPins,
    input wire logic [7:0] portOut
);
    logic [WORD_W-1:0] held;
    logic gone;
    logic jmp;
    logic [7:0] mask;
    assign jmp = !gone && held[13:12] == 2'b10;
    assign mask = 8'h01 << held[9:7];
    // blind to skips: only branches mark the next word dropped
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            held <= '0;
            gone <= 1'b1;
        end else if ($changed(progAddr)) begin
            held <= $past(progData);
            gone <= jmp;
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);
    AST_CYCLE_HOLD: assert property ($changed(progAddr) |=> $stable(progAddr) [*3])
        else $error("fetch address moved early");
    AST_BRANCH_TARGET: assert property ($changed(progAddr) && jmp
        |-> progAddr[10:0] == held[10:0]) else $error("branch target wrong");
    AST_STEP_ONE: assert property ($changed(progAddr) && !jmp
        |-> progAddr == $past(progAddr) + 13'h1) else $error("fetch did not step by one");
    // pins pass two flops, so the executing edge sees them two edges back, the check edge three
    AST_PORT_BIT: assert property ($changed(progAddr) && !gone && held[13:11] == 3'b010
        && held[6:0] == FA_PORT |-> portOut == (held[10] ? $past(portPins, 3) | mask
        : $past(portPins, 3) & ~mask)) else $error("port bit write wrong");
    AST_PORT_INV: assert property ($changed(progAddr) && !gone
        && held == {OPC_INVERT, 1'b1, FA_PORT} |-> portOut == ~$past(portPins, 3))
        else $error("port invert wrong");
    AST_PORT_ZERO: assert property ($changed(progAddr) && !gone
        && held == {OPC_CLEAR, 1'b1, FA_PORT} |-> portOut == 8'h00)
        else $error("port zeroize wrong");
    AST_PORT_INC: assert property ($changed(progAddr) && !gone
        && held == {OPC_INC, 1'b1, FA_PORT} |-> portOut == $past(portPins, 3) + 8'h01)
        else $error("port increment wrong");
    AST_PORT_DEC: assert property ($changed(progAddr) && !gone
        && held == {OPC_DEC, 1'b1, FA_PORT} |-> portOut == $past(portPins, 3) - 8'h01)
        else $error("port decrement wrong");
endmodule // bbl_core_monitor
bind bbl_core bbl_core_monitor i_mon (.clk(clk), .reset(reset), .progAddr(progAddr),
    .progData(progData), .portPins(portPins), .portOut(portOut));
`default_nettype wire

// *** bbl_pkg.sv ***
// constants, opcode fields and bus map of the instruction core
// assumes one 100 MHz clock and a classic wishbone master
package bbl_pkg;

    // four clocks make one instruction cycle
    localparam int INSTR_CYCLE_CLKS = 4;

    // instruction word fields
    localparam int WORD_W = 14;
    localparam int PC_W = 13;
    localparam int OPC_HI = 13;
    localparam int OPC_LO = 8;
    localparam int DEST_BIT = 7;
    localparam int FADDR_HI = 6;
    localparam int BITNO_HI = 9;
    localparam int BITNO_LO = 7;
    localparam int JUMP_HI = 10;
    localparam int PCLATCH_HI = 4;
    localparam int PCLATCH_LO = 3;

    // byte oriented opcodes, bits 13..8
    localparam logic [5:0] OPC_ADD_FILE = 6'h07;
    localparam logic [5:0] OPC_AND_FILE = 6'h05;
    localparam logic [5:0] OPC_CLEAR = 6'h01;
    localparam logic [5:0] OPC_INVERT = 6'h09;
    localparam logic [5:0] OPC_DEC = 6'h03;
    localparam logic [5:0] OPC_DEC_SKIP = 6'h0b;
    localparam logic [5:0] OPC_INC = 6'h0a;
    localparam logic [5:0] OPC_INC_SKIP = 6'h0f;
    localparam logic [5:0] OPC_OR_FILE = 6'h04;
    localparam logic [13:0] WORD_WATCHDOG_KICK = 14'h0064;
    // literal opcodes under class 11, and/or in bits 11..8, add in bits 11..9
    localparam logic [3:0] OPC_AND_LIT = 4'h9;
    localparam logic [3:0] OPC_OR_LIT = 4'h8;
    localparam logic [2:0] OPC_ADD_LIT = 3'h7;

    // special file addresses
    localparam logic [6:0] FA_TIMER = 7'h01;
    localparam logic [6:0] FA_STATUS = 7'h03;
    localparam logic [6:0] FA_PORT = 7'h06;
    localparam logic [6:0] FA_PCLATCH = 7'h0a;

    // status bit positions and reset value
    localparam int ST_CARRY = 0;
    localparam int ST_NIBBLE = 1;
    localparam int ST_ZERO = 2;
    localparam int ST_SLEEP = 3;
    localparam int ST_EXPIRY = 4;
    localparam logic [7:0] STATUS_RESET = 8'h18;

    // wishbone map, byte addresses
    localparam logic [7:0] ADR_CTRL = 8'h00;
    localparam logic [7:0] ADR_CORE = 8'h04;
    localparam logic [7:0] ADR_TIMERS = 8'h08;
    localparam logic [7:0] ADR_STACK = 8'h0c;
    localparam int CTRL_RUN = 0;
    localparam int CTRL_PRESC_TIMER = 1;
    localparam int CTRL_RATE_LO = 2;
    localparam int CTRL_RATE_HI = 4;
    localparam logic [7:0] CTRL_RESET = 8'h00;

    localparam int STACK_DEPTH = 8;
    localparam int FILE_DEPTH = 128;

    typedef enum logic [3:0] {
        PH0 = 4'b0001,
        PH1 = 4'b0010,
        PH2 = 4'b0100,
        PH3 = 4'b1000
    } bbl_phase_t;

    typedef enum logic [4:0] {
        OP_NONE, OP_ADD_LIT_ACC, OP_ADD_ACC_FILE, OP_AND_LIT_ACC, OP_AND_ACC_FILE,
        OP_OR_LIT_ACC, OP_OR_ACC_FILE, OP_FILE_ZERO, OP_ACC_ZERO, OP_FILE_INV,
        OP_FILE_DEC, OP_FILE_DEC_SKIP, OP_FILE_INC, OP_FILE_INC_SKIP,
        OP_BIT_CLEAR, OP_BIT_SET, OP_SKIP_CLEAR, OP_SKIP_SET,
        OP_CALL, OP_JUMP, OP_WATCHDOG_KICK
    } bbl_op_t;

endpackage

// *** bbl_prog_mem.sv ***
// program memory model, 64 words, loaded by the bench
// assumes the bench writes words only while the core is in reset
`timescale 1ns/1ns
`default_nettype none
module bbl_prog_mem
    import bbl_pkg::*;
(
    input wire logic [PC_W-1:0] progAddr,
    output logic [WORD_W-1:0] progData
);
    logic [WORD_W-1:0] mem [64];
    // upper address bits ignored, so paged targets alias
    assign progData = mem[progAddr[5:0]];
endmodule // bbl_prog_mem
`default_nettype wire
